// *** ghso_pkg.sv ***
// Purpose: Shared constants for the guard hinge safety output logic
// Assumes: 250 MHz clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package ghso_pkg;
   // Register byte offsets
   localparam logic [7:0] GHSO_STATUS_OFS   = 8'h00;
   localparam logic [7:0] GHSO_IRQ_STAT_OFS = 8'h04;
   localparam logic [7:0] GHSO_IRQ_MASK_OFS = 8'h08;
   localparam logic [7:0] GHSO_CTRL_OFS     = 8'h0c;
   localparam logic [7:0] GHSO_LAMP_OFS     = 8'h10;
   // Status register field positions
   localparam int GHSO_ST_OUT_POS   = 0;
   localparam int GHSO_ST_ACT_POS   = 1;
   localparam int GHSO_ST_COND_POS  = 2;
   localparam int GHSO_ST_LIMIT_POS = 3;
   localparam int GHSO_ST_STATE_POS = 4;
   // Interrupt event bit positions
   localparam int GHSO_EV_INPUT_OFF = 0;
   localparam int GHSO_EV_PARTIAL   = 1;
   localparam int GHSO_EV_OUT_FAULT = 2;
   localparam int GHSO_EV_INT_FAULT = 3;
   localparam int GHSO_EV_ON        = 4;
   localparam int GHSO_EV_W         = 5;
   // Control fields
   localparam int GHSO_CTRL_INJECT_POS = 0;
   // Reset values
   localparam logic [4:0] GHSO_MASK_RST = 5'h00;
   localparam logic [0:0] GHSO_CTRL_RST = 1'h0;
   // Timing
   localparam int GHSO_CLK_MHZ      = 250;
   localparam int GHSO_SELFTEST_US  = 10;
   localparam int GHSO_SELFTEST_CYC = GHSO_SELFTEST_US * GHSO_CLK_MHZ;
   localparam int GHSO_MISMATCH_NS  = 1000;
   localparam int GHSO_MISMATCH_CYC = GHSO_MISMATCH_NS * GHSO_CLK_MHZ / 1000;
   localparam int GHSO_FLASH_MS     = 250;
   localparam int GHSO_FLASH_CYC    = GHSO_FLASH_MS * GHSO_CLK_MHZ * 1000;
   localparam int GHSO_CHAIN_MAX    = 32;
   // Lamp colour codes
   localparam logic [1:0] GHSO_LAMP_OFF    = 2'h0;
   localparam logic [1:0] GHSO_LAMP_GREEN  = 2'h1;
   localparam logic [1:0] GHSO_LAMP_ORANGE = 2'h2;
   localparam logic [1:0] GHSO_LAMP_RED    = 2'h3;
   // Device states
   typedef enum logic [2:0] {
      GHSO_SELFTEST,
      GHSO_RUN,
      GHSO_INPUT_LOCK,
      GHSO_PARTIAL_LOCK,
      GHSO_OUT_FAULT,
      GHSO_INT_FAULT
   } ghso_state_t;
endpackage : ghso_pkg

// *** ghso_apb_regs.sv ***
// Purpose: APB slave holding control, interrupt status and mask
// Assumes: zero wait states, 32-bit data, aligned words
// Notes:   Status bits are write-one-to-clear; a new event wins over clear
`timescale 1ns/10ps
module ghso_apb_regs
   import ghso_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   input  wire logic [GHSO_EV_W-1:0] event_i,
   input  wire logic [31:0]         status_i,
   input  wire logic [31:0]         lamp_i,
   output logic                     inject_o,
   output logic                     irq_o
);
   logic [GHSO_EV_W-1:0] irq_stat;
   logic [GHSO_EV_W-1:0] irq_mask;
   logic                 wr_en;
   logic                 rd_en;
   logic                 hit;
   logic [31:0]          next_rdata;

   // Access decode, single-cycle answer
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign hit       = (paddr_i == GHSO_STATUS_OFS) | (paddr_i == GHSO_IRQ_STAT_OFS)
                    | (paddr_i == GHSO_IRQ_MASK_OFS) | (paddr_i == GHSO_CTRL_OFS)
                    | (paddr_i == GHSO_LAMP_OFS);
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign irq_o     = |(irq_stat & irq_mask);

   // Sticky event bits, set beats clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_stat <= '0;
      end else if (wr_en && paddr_i == GHSO_IRQ_STAT_OFS) begin
         irq_stat <= (irq_stat & ~pwdata_i[GHSO_EV_W-1:0]) | event_i;
      end else begin
         irq_stat <= irq_stat | event_i;
      end
   end

   // Mask and control registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask <= GHSO_MASK_RST;
         inject_o <= GHSO_CTRL_RST;
      end else if (wr_en) begin
         if (paddr_i == GHSO_IRQ_MASK_OFS) irq_mask <= pwdata_i[GHSO_EV_W-1:0];
         if (paddr_i == GHSO_CTRL_OFS) inject_o <= pwdata_i[GHSO_CTRL_INJECT_POS];
      end
   end

   // Read mux, captured in setup so data stands in access
   always_comb begin
      unique case (paddr_i)
         GHSO_STATUS_OFS:   next_rdata = status_i;
         GHSO_IRQ_STAT_OFS: next_rdata = {{(32-GHSO_EV_W){1'b0}}, irq_stat};
         GHSO_IRQ_MASK_OFS: next_rdata = {{(32-GHSO_EV_W){1'b0}}, irq_mask};
         GHSO_CTRL_OFS:     next_rdata = {31'h0, inject_o};
         GHSO_LAMP_OFS:     next_rdata = lamp_i;
         default:           next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) prdata_o <= 32'h0;
      else if (rd_en) prdata_o <= next_rdata;
   end
endmodule : ghso_apb_regs

// *** ghso_top.sv ***
// Purpose: Monitoring logic of a guard hinge safety switch with electronic outputs
// Assumes: inputs synchronous to CLOCK_I; SRST_I stands for supply removal
// Notes:   Lamps are 2-bit colour codes; flashing alternates two colours
//          Readback is judged only while the pair is driven on
//
// Function
// - Input condition fulfilled only when both enable inputs are high.
// - Input condition and sensing channel agreement are checked continuously.
// - Either enable dropping while outputs on switches both outputs off.
// - After input shutdown, both enables must go low then high again.
// - Slow or slight partial opening switches both safety outputs off.
// - After partial opening, actuator must open fully and close again.
// - Actuator present, inputs unfulfilled: outputs off, status on, actuator lamp green.
// - Nothing present: outputs and status off, only power lamp green.
// - Actuator at limit, inputs not fulfilled: actuator lamp flashes, status on.
// - Output fault: outputs and status off, supply lamp green, output lamp flashes red until restart.
// - Fundamental error: supply lamp red, other lamps off, held until supply removal.
// - Up to 32 switches chain, each output feeds next inputs.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module ghso_top
   import ghso_pkg::*;
#(
   parameter int SELFTEST_CYC = GHSO_SELFTEST_CYC,
   parameter int FLASH_CYC    = GHSO_FLASH_CYC
)(
   input  wire logic        CLOCK_I,
   input  wire logic        SRST_I,
   input  wire logic        ENABLE_A_I,
   input  wire logic        ENABLE_B_I,
   input  wire logic        SENSE_CLOSED_A_I,
   input  wire logic        SENSE_CLOSED_B_I,
   input  wire logic        SENSE_LIMIT_I,
   input  wire logic        SENSE_OPEN_I,
   input  wire logic        OUT_READBACK_A_I,
   input  wire logic        OUT_READBACK_B_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   output logic             SAFETY_SWITCH_PAIR_A_O,
   output logic             SAFETY_SWITCH_PAIR_B_O,
   output logic             ACTUATOR_STATUS_SIGNAL_O,
   output logic [1:0]       SUPPLY_LAMP_O,
   output logic [1:0]       SWITCH_STATE_LAMP_O,
   output logic [1:0]       ENABLE_STATE_LAMP_O,
   output logic [1:0]       HINGE_POSITION_LAMP_O,
   output logic             IRQ_O
);
   ghso_state_t           state;
   ghso_state_t           next_state;
   logic [31:0]           st_cnt;
   logic [31:0]           fl_cnt;
   logic                  flash;
   logic [8:0]            mm_cnt;
   logic                  cond_ok;
   logic                  cond_irr;
   logic                  act_det;
   logic                  at_limit;
   logic                  chan_err;
   logic                  outs_on;
   logic                  enables_low_seen;
   logic                  open_seen;
   logic                  out_fault;
   logic                  inject;
   logic                  prev_on;
   logic [GHSO_EV_W-1:0]  events;
   logic [31:0]           status_word;
   logic [31:0]           lamp_word;

   // Flashing colour pair helper
   function automatic logic [1:0] ghso_flash_col(input logic ph, input logic [1:0] c1,
                                                 input logic [1:0] c2);
      ghso_flash_col = ph ? c1 : c2;
   endfunction : ghso_flash_col

   // Pair drive for the coming cycle, shared by outputs, lamps and events
   function automatic logic ghso_on_next(input logic on_now, input ghso_state_t nxt);
      ghso_on_next = on_now & (nxt == GHSO_RUN);
   endfunction : ghso_on_next

   // Input condition decode
   assign cond_ok  = ENABLE_A_I & ENABLE_B_I;
   assign cond_irr = ENABLE_A_I ^ ENABLE_B_I;
   // Actuator decode from redundant channels
   assign act_det  = SENSE_CLOSED_A_I & SENSE_CLOSED_B_I & ~SENSE_LIMIT_I;
   assign at_limit = SENSE_CLOSED_A_I & SENSE_CLOSED_B_I & SENSE_LIMIT_I;
   assign outs_on  = (state == GHSO_RUN) & cond_ok & (act_det | at_limit);

   // Channel disagreement filter, persistent mismatch is internal error
   // Counter saturates while the mismatch lasts and clears when it ends; GHSO_INT_FAULT holds the error until supply removal
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         mm_cnt <= 9'h000;
      end else if ((SENSE_CLOSED_A_I ^ SENSE_CLOSED_B_I) | (SENSE_OPEN_I & SENSE_CLOSED_A_I)) begin
         if (mm_cnt != 9'(GHSO_MISMATCH_CYC)) mm_cnt <= mm_cnt + 9'h001;
      end else begin
         mm_cnt <= 9'h000;
      end
   end
   assign chan_err = (mm_cnt == 9'(GHSO_MISMATCH_CYC)) | inject;

   // Output readback mismatch means cross connection or short
   // Only weighed while on, so the switching edges never trip it
   assign out_fault = (OUT_READBACK_A_I != SAFETY_SWITCH_PAIR_A_O)
                    | (OUT_READBACK_B_I != SAFETY_SWITCH_PAIR_B_O);

   // Self-test timer
   // Counts only in self-test; coming back there needs a reset
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) st_cnt <= 32'h0;
      else if (state == GHSO_SELFTEST) st_cnt <= st_cnt + 32'h1;
      else st_cnt <= 32'h0;
   end

   // Flash phase generator
   // Free running, so all flashing lamps share one phase
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         fl_cnt <= 32'h0;
         flash  <= 1'b0;
      end else if (fl_cnt >= 32'(FLASH_CYC - 1)) begin
         fl_cnt <= 32'h0;
         flash  <= ~flash;
      end else begin
         fl_cnt <= fl_cnt + 32'h1;
      end
   end

   // Re-arm tracking for lock states
   // Both flags drop outside their lock state, so old history cannot re-arm
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         enables_low_seen <= 1'b0;
         open_seen        <= 1'b0;
      end else begin
         if (state != GHSO_INPUT_LOCK) enables_low_seen <= 1'b0;
         else if (~ENABLE_A_I & ~ENABLE_B_I) enables_low_seen <= 1'b1;
         if (state != GHSO_PARTIAL_LOCK) open_seen <= 1'b0;
         else if (SENSE_OPEN_I & ~SENSE_CLOSED_A_I & ~SENSE_CLOSED_B_I)
            open_seen <= 1'b1;
      end
   end

   // Main state transitions
   always_comb begin
      next_state = state;
      unique case (state)
         GHSO_SELFTEST: begin
            if (chan_err) next_state = GHSO_INT_FAULT;
            else if (st_cnt >= 32'(SELFTEST_CYC - 1)) next_state = GHSO_RUN;
         end
         GHSO_RUN: begin
            if (chan_err) next_state = GHSO_INT_FAULT;
            else if (outs_on && out_fault) next_state = GHSO_OUT_FAULT;
            else if (prev_on && !cond_ok) next_state = GHSO_INPUT_LOCK;
            else if (prev_on && !act_det && !at_limit && !SENSE_OPEN_I)
               next_state = GHSO_PARTIAL_LOCK;
         end
         GHSO_INPUT_LOCK: begin
            if (chan_err) next_state = GHSO_INT_FAULT;
            else if (enables_low_seen && cond_ok) next_state = GHSO_RUN;
         end
         GHSO_PARTIAL_LOCK: begin
            if (chan_err) next_state = GHSO_INT_FAULT;
            else if (open_seen && act_det) next_state = GHSO_RUN;
         end
         GHSO_OUT_FAULT: next_state = chan_err ? GHSO_INT_FAULT : GHSO_OUT_FAULT;
         GHSO_INT_FAULT: next_state = GHSO_INT_FAULT;
         default:        next_state = GHSO_INT_FAULT;
      endcase
   end

   // State register; supply removal restarts the self-test
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) state <= GHSO_SELFTEST;
      else state <= next_state;
   end

   // Remember that outputs were on last cycle
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) prev_on <= 1'b0;
      else prev_on <= ghso_on_next(outs_on, next_state);
   end

   // Safety outputs and status signal, registered
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         SAFETY_SWITCH_PAIR_A_O   <= 1'b0;
         SAFETY_SWITCH_PAIR_B_O   <= 1'b0;
         ACTUATOR_STATUS_SIGNAL_O <= 1'b0;
      end else begin
         // Both outputs always move together
         SAFETY_SWITCH_PAIR_A_O   <= ghso_on_next(outs_on, next_state);
         SAFETY_SWITCH_PAIR_B_O   <= ghso_on_next(outs_on, next_state);
         ACTUATOR_STATUS_SIGNAL_O <= (next_state != GHSO_SELFTEST) && (next_state != GHSO_OUT_FAULT)
                                   && (next_state != GHSO_INT_FAULT)
                                   && (act_det || (at_limit && !cond_ok));
      end
   end

   // Lamp driving
   // Colours follow the coming state to stay in step with the outputs
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         SUPPLY_LAMP_O         <= GHSO_LAMP_ORANGE;
         SWITCH_STATE_LAMP_O   <= GHSO_LAMP_OFF;
         ENABLE_STATE_LAMP_O   <= GHSO_LAMP_OFF;
         HINGE_POSITION_LAMP_O <= GHSO_LAMP_OFF;
      end else begin
         unique case (next_state)
            GHSO_SELFTEST: begin
               SUPPLY_LAMP_O         <= GHSO_LAMP_ORANGE;
               SWITCH_STATE_LAMP_O   <= GHSO_LAMP_OFF;
               ENABLE_STATE_LAMP_O   <= GHSO_LAMP_OFF;
               HINGE_POSITION_LAMP_O <= GHSO_LAMP_OFF;
            end
            GHSO_OUT_FAULT: begin
               SUPPLY_LAMP_O         <= GHSO_LAMP_GREEN;
               SWITCH_STATE_LAMP_O   <= flash ? GHSO_LAMP_RED : GHSO_LAMP_OFF;
               ENABLE_STATE_LAMP_O   <= GHSO_LAMP_OFF;
               HINGE_POSITION_LAMP_O <= GHSO_LAMP_OFF;
            end
            GHSO_INT_FAULT: begin
               SUPPLY_LAMP_O         <= GHSO_LAMP_RED;
               SWITCH_STATE_LAMP_O   <= GHSO_LAMP_OFF;
               ENABLE_STATE_LAMP_O   <= GHSO_LAMP_OFF;
               HINGE_POSITION_LAMP_O <= GHSO_LAMP_OFF;
            end
            default: begin
               SUPPLY_LAMP_O       <= GHSO_LAMP_GREEN;
               SWITCH_STATE_LAMP_O <= ghso_on_next(outs_on, next_state)
                                    ? GHSO_LAMP_GREEN : GHSO_LAMP_OFF;
               if (cond_irr)
                  ENABLE_STATE_LAMP_O <= ghso_flash_col(flash, GHSO_LAMP_ORANGE, GHSO_LAMP_GREEN);
               else
                  ENABLE_STATE_LAMP_O <= cond_ok ? GHSO_LAMP_GREEN : GHSO_LAMP_OFF;
               if (at_limit)
                  HINGE_POSITION_LAMP_O <= ghso_flash_col(flash, GHSO_LAMP_ORANGE,
                                                          GHSO_LAMP_GREEN);
               else
                  HINGE_POSITION_LAMP_O <= act_det ? GHSO_LAMP_GREEN : GHSO_LAMP_OFF;
            end
         endcase
      end
   end

   // Events for the interrupt block
   // Single-cycle pulses, kept sticky by the register block
   always_comb begin
      events                    = '0;
      events[GHSO_EV_INPUT_OFF] = (state == GHSO_RUN) && (next_state == GHSO_INPUT_LOCK);
      events[GHSO_EV_PARTIAL]   = (state == GHSO_RUN) && (next_state == GHSO_PARTIAL_LOCK);
      events[GHSO_EV_OUT_FAULT] = (state != GHSO_OUT_FAULT) && (next_state == GHSO_OUT_FAULT);
      events[GHSO_EV_INT_FAULT] = (state != GHSO_INT_FAULT) && (next_state == GHSO_INT_FAULT);
      events[GHSO_EV_ON]        = !prev_on && ghso_on_next(outs_on, next_state);
   end

   // Read-back words
   // State code is exposed for diagnosis over the bus
   assign status_word = {25'h0, state, at_limit, cond_ok, act_det, SAFETY_SWITCH_PAIR_A_O};
   assign lamp_word   = {24'h0, HINGE_POSITION_LAMP_O, ENABLE_STATE_LAMP_O,
                         SWITCH_STATE_LAMP_O, SUPPLY_LAMP_O};

   // Register file and interrupt
   // Unmapped offsets answer with an error and read as zero
   ghso_apb_regs u_regs (
      .clk_i     (CLOCK_I),
      .srst_i    (SRST_I),
      .psel_i    (PSEL_I),
      .penable_i (PENABLE_I),
      .pwrite_i  (PWRITE_I),
      .paddr_i   (PADDR_I),
      .pwdata_i  (PWDATA_I),
      .prdata_o  (PRDATA_O),
      .pready_o  (PREADY_O),
      .pslverr_o (PSLVERR_O),
      .event_i   (events),
      .status_i  (status_word),
      .lamp_i    (lamp_word),
      .inject_o  (inject),
      .irq_o     (IRQ_O)
   );
endmodule : ghso_top

// *** ghso_top_asserts.sv ***
// Purpose: Port-level checks of the guard hinge safety output logic
// Assumes: one clock domain, synchronous active-high reset
// Notes:   Attached to every ghso_top by the bind at the foot of this file
`timescale 1ns/10ps
module ghso_top_asserts
   import ghso_pkg::*;
(
   input wire logic       CLOCK_I,
   input wire logic       SRST_I,
   input wire logic       ENABLE_A_I,
   input wire logic       ENABLE_B_I,
   input wire logic       SENSE_CLOSED_A_I,
   input wire logic       SENSE_CLOSED_B_I,
   input wire logic       OUT_READBACK_A_I,
   input wire logic       SAFETY_SWITCH_PAIR_A_O,
   input wire logic       SAFETY_SWITCH_PAIR_B_O,
   input wire logic       ACTUATOR_STATUS_SIGNAL_O,
   input wire logic [1:0] SUPPLY_LAMP_O,
   input wire logic [1:0] SWITCH_STATE_LAMP_O,
   input wire logic       IRQ_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // Output pair and enabling conditions
   AST_PAIR_EQUAL: assert property (SAFETY_SWITCH_PAIR_A_O == SAFETY_SWITCH_PAIR_B_O)
      else $error("safety outputs disagree");
   AST_ON_NEEDS_BOTH: assert property (SAFETY_SWITCH_PAIR_A_O |-> $past(ENABLE_A_I && ENABLE_B_I))
      else $error("outputs on without both enables");
   AST_DROP_OFF: assert property (SAFETY_SWITCH_PAIR_A_O && !(ENABLE_A_I && ENABLE_B_I) |=>
      !SAFETY_SWITCH_PAIR_A_O)
      else $error("outputs stayed on after enable drop");
   AST_IDLE_OFF: assert property (!SENSE_CLOSED_A_I && !SENSE_CLOSED_B_I |=>
      !ACTUATOR_STATUS_SIGNAL_O && !SAFETY_SWITCH_PAIR_A_O)
      else $error("outputs on without actuator");
   AST_SELFTEST: assert property ($fell(SRST_I) |->
      (SUPPLY_LAMP_O == GHSO_LAMP_ORANGE && !SAFETY_SWITCH_PAIR_A_O)[*4])
      else $error("self-test indication wrong");
   AST_ON_GREEN: assert property (SAFETY_SWITCH_PAIR_A_O && $past(SAFETY_SWITCH_PAIR_A_O) |->
      SUPPLY_LAMP_O == GHSO_LAMP_GREEN && SWITCH_STATE_LAMP_O == GHSO_LAMP_GREEN)
      else $error("lamps not green while on");
   AST_READBACK: assert property (SAFETY_SWITCH_PAIR_A_O && OUT_READBACK_A_I != SAFETY_SWITCH_PAIR_A_O |->
      ##[1:3] (!SAFETY_SWITCH_PAIR_A_O && !ACTUATOR_STATUS_SIGNAL_O))
      else $error("output fault not acted on");
   AST_FAULT_HOLD: assert property (SUPPLY_LAMP_O == GHSO_LAMP_RED |-> (!SAFETY_SWITCH_PAIR_A_O)[*8])
      else $error("outputs on during internal fault");
   // Main scenarios reached
   cover property ($rose(SAFETY_SWITCH_PAIR_A_O));
   cover property (SAFETY_SWITCH_PAIR_A_O && !OUT_READBACK_A_I);
   cover property ($rose(IRQ_O));
endmodule : ghso_top_asserts

bind ghso_top ghso_top_asserts u_chk (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ENABLE_A_I(ENABLE_A_I),
   .ENABLE_B_I(ENABLE_B_I), .SENSE_CLOSED_A_I(SENSE_CLOSED_A_I), .SENSE_CLOSED_B_I(SENSE_CLOSED_B_I),
   .OUT_READBACK_A_I(OUT_READBACK_A_I), .SAFETY_SWITCH_PAIR_A_O(SAFETY_SWITCH_PAIR_A_O),
   .SAFETY_SWITCH_PAIR_B_O(SAFETY_SWITCH_PAIR_B_O), .ACTUATOR_STATUS_SIGNAL_O(ACTUATOR_STATUS_SIGNAL_O),
   .SUPPLY_LAMP_O(SUPPLY_LAMP_O), .SWITCH_STATE_LAMP_O(SWITCH_STATE_LAMP_O), .IRQ_O(IRQ_O));

// *** ghso_partner.sv ***
// Purpose: Upstream chain member driving the enables, and output readback
// Assumes: requests change after a rising edge
// Notes:   Readback fault inverts channel A to mimic a cross connection
`timescale 1ns/10ps
module ghso_partner (
   input  wire logic clk_i,
   input  wire logic want_a_i,
   input  wire logic want_b_i,
   input  wire logic rb_fault_i,
   input  wire logic out_a_i,
   input  wire logic out_b_i,
   output logic      en_a_o = 1'b0,
   output logic      en_b_o = 1'b0,
   output logic      rb_a_o,
   output logic      rb_b_o
);
   // Enables follow the upstream safety state one cycle late
   always @(posedge clk_i) begin
      en_a_o <= want_a_i;
      en_b_o <= want_b_i;
   end
   // Readback of the switching outputs
   assign rb_a_o = out_a_i ^ rb_fault_i;
   assign rb_b_o = out_b_i;
endmodule : ghso_partner

// *** ghso_top_tb_top.sv ***
// Purpose: Self-checking bench of the guard hinge safety output logic
// Assumes: shortened self-test and flash counts
// Notes:   One task per scenario, APB reached through one bus task
`timescale 1ns/10ps
module ghso_top_tb_top;
   import ghso_pkg::*;
   logic        clk = 0, srst = 1, want_a = 0, want_b = 0, rb_fault = 0;
   logic        closed_a = 0, closed_b = 0, limit = 0, sense_open = 0;
   logic        psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  seen;
   wire         en_a, en_b, rb_a, rb_b, out_a, out_b, status, pready, pslverr, irq;
   wire  [1:0]  lamp_sup, lamp_sw, lamp_en, lamp_hg;
   int          err_total = 0, n_compared = 0;

   ghso_top #(.SELFTEST_CYC(8), .FLASH_CYC(4)) uut (.CLOCK_I(clk), .SRST_I(srst), .ENABLE_A_I(en_a),
      .ENABLE_B_I(en_b), .SENSE_CLOSED_A_I(closed_a), .SENSE_CLOSED_B_I(closed_b), .SENSE_LIMIT_I(limit),
      .SENSE_OPEN_I(sense_open), .OUT_READBACK_A_I(rb_a), .OUT_READBACK_B_I(rb_b), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .SAFETY_SWITCH_PAIR_A_O(out_a), .SAFETY_SWITCH_PAIR_B_O(out_b),
      .ACTUATOR_STATUS_SIGNAL_O(status), .SUPPLY_LAMP_O(lamp_sup), .SWITCH_STATE_LAMP_O(lamp_sw),
      .ENABLE_STATE_LAMP_O(lamp_en), .HINGE_POSITION_LAMP_O(lamp_hg), .IRQ_O(irq));
   ghso_partner u_far (.clk_i(clk), .want_a_i(want_a), .want_b_i(want_b), .rb_fault_i(rb_fault),
      .out_a_i(out_a), .out_b_i(out_b), .en_a_o(en_a), .en_b_o(en_b), .rb_a_o(rb_a), .rb_b_o(rb_b));

   // Clock at 250 MHz
   initial begin
      forever #2 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task sense(input logic a, input logic b, input logic l, input logic o);
      closed_a <= a;
      closed_b <= b;
      limit <= l;
      sense_open <= o;
   endtask : sense

   task en(input logic a, input logic b);
      want_a <= a;
      want_b <= b;
   endtask : en

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task reset_dut;
      srst <= 1'b1;
      cyc(4);
      srst <= 1'b0;
      cyc(3);
      chk("supply_selftest", GHSO_LAMP_ORANGE, lamp_sup);
      chk("out_selftest", 0, out_a);
      cyc(12);
      chk("supply_run", GHSO_LAMP_GREEN, lamp_sup);
   endtask : reset_dut

   task t_idle;
      chk("idle_out", 0, {out_a, out_b, status});
      chk("idle_lamps", 0, {lamp_sw, lamp_en, lamp_hg});
      chk("pready", 1, pready);
      apb(1'b0, GHSO_IRQ_MASK_OFS, 32'h0);
      chk("mask_reset", {27'h0, GHSO_MASK_RST}, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped_err", 1, err);
      chk("unmapped_rd", 0, rd);
   endtask : t_idle

   task t_actuator_on;
      sense(1, 1, 0, 0);
      cyc(4);
      chk("act_only", 3'b001, {out_a, out_b, status});
      chk("act_lamps", {GHSO_LAMP_GREEN, GHSO_LAMP_OFF}, {lamp_hg, lamp_en});
      en(1, 1);
      cyc(4);
      chk("all_on", 3'b111, {out_a, out_b, status});
      chk("all_green", 8'h55, {lamp_sup, lamp_sw, lamp_en, lamp_hg});
      apb(1'b0, GHSO_STATUS_OFS, 32'h0);
      chk("status_reg", 32'h17, rd);
      apb(1'b0, GHSO_LAMP_OFS, 32'h0);
      chk("lamp_reg", 32'h55, rd);
   endtask : t_actuator_on

   task t_input_lock;
      en(1, 0);
      cyc(4);
      chk("one_enable", 0, {out_a, out_b});
      en(1, 1);
      cyc(4);
      chk("no_rearm", 0, {out_a, out_b});
      en(0, 0);
      cyc(4);
      en(1, 1);
      cyc(4);
      chk("rearm", 3, {out_a, out_b});
   endtask : t_input_lock

   task t_partial;
      sense(0, 0, 0, 0);
      cyc(4);
      chk("partial_off", 0, {out_a, out_b});
      sense(1, 1, 0, 0);
      cyc(4);
      chk("partial_lock", 0, {out_a, out_b});
      sense(0, 0, 0, 1);
      cyc(4);
      sense(1, 1, 0, 0);
      cyc(4);
      chk("partial_rearm", 3, {out_a, out_b});
      apb(1'b0, GHSO_IRQ_STAT_OFS, 32'h0);
      chk("events_seen", 32'h13, rd);
   endtask : t_partial

   task t_limit;
      en(0, 0);
      sense(1, 1, 1, 0);
      cyc(4);
      chk("limit_out", 3'b001, {out_a, out_b, status});
      seen = 0;
      repeat (12) begin
         @(posedge clk);
         seen = seen | (4'h1 << lamp_hg);
      end
      chk("limit_flash", 4'b0110, seen & 4'b0110);
      sense(1, 1, 0, 0);
   endtask : t_limit

   task t_out_fault;
      en(1, 1);
      cyc(4);
      chk("fault_pre", 3, {out_a, out_b});
      rb_fault <= 1'b1;
      cyc(4);
      rb_fault <= 1'b0;
      seen = 0;
      repeat (12) begin
         @(posedge clk);
         seen = seen | (4'h1 << lamp_sw);
      end
      chk("fault_off", 0, {out_a, out_b, status});
      chk("fault_red", 1, seen[3]);
      chk("irq_masked", 0, irq);
      apb(1'b0, GHSO_IRQ_STAT_OFS, 32'h0);
      chk("irq_stat", 1, rd[GHSO_EV_OUT_FAULT]);
      apb(1'b1, GHSO_IRQ_MASK_OFS, 32'h1 << GHSO_EV_OUT_FAULT);
      cyc(2);
      chk("irq_raised", 1, irq);
      apb(1'b1, GHSO_IRQ_STAT_OFS, 32'h1f);
      cyc(2);
      chk("irq_cleared", 0, irq);
      en(0, 0);
   endtask : t_out_fault

   task t_int_fault;
      reset_dut();
      en(1, 1);
      cyc(4);
      chk("int_pre", 3, {out_a, out_b});
      apb(1'b1, GHSO_CTRL_OFS, 32'h1);
      cyc(4);
      chk("int_off", 0, {out_a, out_b});
      apb(1'b1, GHSO_CTRL_OFS, 32'h0);
      cyc(20);
      chk("int_held", {GHSO_LAMP_RED, 2'b00}, {lamp_sup, out_a, out_b});
      en(0, 0);
      reset_dut();
      sense(1, 0, 0, 0);
      cyc(200);
      chk("mismatch_wait", GHSO_LAMP_GREEN, lamp_sup);
      cyc(60);
      chk("mismatch_fault", GHSO_LAMP_RED, lamp_sup);
      sense(1, 1, 0, 0);
      reset_dut();
   endtask : t_int_fault

   task give_verdict;
      $display("Comparisons %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // Hang guard
   initial begin
      cyc(20000);
      err_total++;
      give_verdict();
   end

   // Main sequence
   initial begin
      reset_dut();
      t_idle();
      t_actuator_on();
      t_input_lock();
      t_partial();
      t_limit();
      t_out_fault();
      t_int_fault();
      give_verdict();
   end
endmodule : ghso_top_tb_top
